// [logic/sos_pkg.sv]
package sos_pkg;
	// input sync modes (selects where the horizontal and vertical inputs come from)
	typedef enum logic [1:0] {
		SOS_MODE_NONE = 2'h0,
		SOS_MODE_SOG = 2'h1,
		SOS_MODE_COMP = 2'h2,
		SOS_MODE_SEP = 2'h3
	} sos_mode_e;

	// horizontal output source
	typedef enum logic [1:0] {
		SOS_H_PLAIN = 2'h0,
		SOS_H_DBL = 2'h1,
		SOS_H_CLAMP = 2'h2,
		SOS_H_GEN = 2'h3
	} sos_hsel_e;

	// selection word as written by software
	typedef struct packed {
		sos_mode_e mode;
		sos_hsel_e hsel;
		logic fall_mod;
		logic h_sync;
		logic vgen;
		logic hfb_inv;
		logic vfb_inv;
	} sos_cfg_s;

	// raw pins and internal sources feeding the block
	typedef struct packed {
		logic hfb;
		logic vfb;
		logic green_cs;
		logic horiz_cs;
		logic vpin;
		logic sep_vert;
		logic dbl_removed;
		logic clamp;
		logic gen_h;
		logic gen_v;
		logic delay_cmp_b;
	} sos_src_s;

	// register map of the plain register port
	localparam logic [3:0] SOS_REG_SEL = 4'h0;
	localparam logic [3:0] SOS_REG_CTRL = 4'h1;
	localparam logic [3:0] SOS_REG_STAT = 4'h2;
	localparam int SOS_CFG_W = 9;
	localparam logic [8:0] SOS_CFG_RESET = 9'h000;
	localparam int SOS_SYNC_STAGES = 3;
	localparam int SOS_SRC_W = 11;
endpackage : sos_pkg

// [logic/sos_pin_sync.sv]
// three-stage synchroniser; a change is taken once stages two and three agree
module sos_pin_sync #(
	parameter int W = 1
) (
	input wire logic clk, // system clock
	input wire logic nrst, // async reset, low
	input wire logic [W-1:0] din, // asynchronous pins
	output logic [W-1:0] dout // filtered level
);
	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;
	wire [W-1:0] agree = ~(s2 ^ s3);
	wire [W-1:0] next_dout = (agree & s3) | (~agree & dout);

	// first stage feeds only the second
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
			dout <= '0;
		end else begin
			s1 <= din;
			s2 <= s1;
			s3 <= s2;
			dout <= next_dout;
		end
	end
endmodule : sos_pin_sync

// [logic/sos_output_select.sv]
// Design decisions made here: the placing of the registers and the strobed register port.
module sos_output_select (
	input wire logic CLOCK, // system clock 25 MHz
	input wire logic NRST, // async reset, low
	input wire logic [3:0] ADDR, // register index
	input wire logic [15:0] WDATA, // write data
	input wire logic WR, // write strobe
	input wire logic RD, // read strobe
	output logic [15:0] RDATA, // read data, cycle after RD
	input wire logic HFB_IN, // horizontal flyback pin
	input wire logic VFB_IN, // vertical flyback pin
	input wire logic GREEN_CS_IN, // green composite sync pin
	input wire logic HORIZ_CS_IN, // horizontal/composite sync pin
	input wire logic VPIN_IN, // dedicated vertical sync pin
	input wire logic SEP_VERT, // separated vertical pulse
	input wire logic DBL_REMOVED, // input with doubled pulses removed
	input wire logic HORIZ_CLAMP, // interval clamp signal
	input wire logic GEN_H, // generated horizontal sync
	input wire logic GEN_V, // generated vertical sync
	input wire logic DELAY_CMP_B, // vertical delay timer compare b pulse
	output logic HORIZ_SYNC_OUT, // horizontal sync out
	output logic VERT_SYNC_OUT, // vertical sync out
	output logic COMP_BLANK_OUT // composite blanking out
);
	sos_pkg::sos_cfg_s cfg;
	sos_pkg::sos_src_s src;
	logic [4:0] pins;
	logic vert_wave;
	logic vert_in_q;
	logic horiz_in_q;
	logic vert_aligned;

	// pins cross from outside the clock domain
	sos_pin_sync #(
		.W(5)
	) u_sync (
		.clk(CLOCK),
		.nrst(NRST),
		.din({HFB_IN, VFB_IN, GREEN_CS_IN, HORIZ_CS_IN, VPIN_IN}),
		.dout(pins)
	);

	// internal sources come from same-clock timer logic
	assign src = '{hfb: pins[4], vfb: pins[3], green_cs: pins[2], horiz_cs: pins[1],
		vpin: pins[0], sep_vert: SEP_VERT, dbl_removed: DBL_REMOVED, clamp: HORIZ_CLAMP,
		gen_h: GEN_H, gen_v: GEN_V, delay_cmp_b: DELAY_CMP_B};

	// polarity-corrected flybacks
	// inversion control
	wire hfb_pos = src.hfb ^ cfg.hfb_inv;
	wire vfb_pos = src.vfb ^ cfg.vfb_inv;

	// horizontal input chosen by mode
	// mode sources
	wire horiz_in = (cfg.mode == sos_pkg::SOS_MODE_NONE) ? src.hfb :
		(cfg.mode == sos_pkg::SOS_MODE_SOG) ? src.green_cs : src.horiz_cs;

	// vertical input chosen by mode
	// vertical sources
	wire vert_in = (cfg.mode == sos_pkg::SOS_MODE_NONE) ? src.vfb :
		(cfg.mode == sos_pkg::SOS_MODE_SEP) ? src.vpin : src.sep_vert;

	// edges of the chosen inputs
	wire vert_rise = vert_in & ~vert_in_q;
	wire vert_fall = ~vert_in & vert_in_q;
	wire horiz_rise = horiz_in & ~horiz_in_q;

	// set on rise, reset on fall or compare
	wire next_vert_wave = vert_rise ? 1'b1 :
		(cfg.fall_mod ? (src.delay_cmp_b ? 1'b0 : vert_wave) :
		(vert_fall ? 1'b0 : vert_wave));

	// fall held until the next horizontal rise; rise passes at once
	// horizontal alignment
	wire next_vert_aligned = next_vert_wave ? 1'b1 : (horiz_rise ? 1'b0 : vert_aligned);

	wire vert_mod = cfg.h_sync ? vert_aligned : vert_wave;

	wire next_vert_out = cfg.vgen ? src.gen_v : vert_mod;

	// horizontal source select; clamp covers both clamp meanings
	wire next_horiz_out = (cfg.hsel == sos_pkg::SOS_H_PLAIN) ? horiz_in :
		(cfg.hsel == sos_pkg::SOS_H_DBL) ? src.dbl_removed :
		(cfg.hsel == sos_pkg::SOS_H_CLAMP) ? src.clamp : src.gen_h;

	// blanking is an or of three terms
	wire next_blank = hfb_pos | vfb_pos | next_vert_out;

	// register decode
	wire sel_wr = WR && (ADDR == sos_pkg::SOS_REG_SEL);
	wire ctrl_wr = WR && (ADDR == sos_pkg::SOS_REG_CTRL);
	wire [15:0] next_rdata = (ADDR == sos_pkg::SOS_REG_SEL) ?
		{11'h000, cfg.mode, cfg.hsel, cfg.vgen} :
		(ADDR == sos_pkg::SOS_REG_CTRL) ?
		{11'h000, cfg.fall_mod, cfg.h_sync, cfg.hfb_inv, cfg.vfb_inv, 1'b0} :
		(ADDR == sos_pkg::SOS_REG_STAT) ?
		{11'h000, src.hfb, src.vfb, HORIZ_SYNC_OUT, VERT_SYNC_OUT, COMP_BLANK_OUT} :
		16'h0000;

	// selections registered, reset to plain input
	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			cfg <= sos_pkg::SOS_CFG_RESET;
		end else begin
			if (sel_wr) begin
				cfg.mode <= sos_pkg::sos_mode_e'(WDATA[4:3]);
				cfg.hsel <= sos_pkg::sos_hsel_e'(WDATA[2:1]);
				cfg.vgen <= WDATA[0];
			end
			if (ctrl_wr) begin
				cfg.fall_mod <= WDATA[4];
				cfg.h_sync <= WDATA[3];
				cfg.hfb_inv <= WDATA[2];
				cfg.vfb_inv <= WDATA[1];
			end
		end
	end

	// read data only in the cycle after the strobe
	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			RDATA <= 16'h0000;
		end else begin
			RDATA <= RD ? next_rdata : 16'h0000;
		end
	end

	// waveform state and outputs
	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			vert_in_q <= 1'b0;
			horiz_in_q <= 1'b0;
			vert_wave <= 1'b0;
			vert_aligned <= 1'b0;
			HORIZ_SYNC_OUT <= 1'b0;
			VERT_SYNC_OUT <= 1'b0;
			COMP_BLANK_OUT <= 1'b0;
		end else begin
			vert_in_q <= vert_in;
			horiz_in_q <= horiz_in;
			vert_wave <= next_vert_wave;
			vert_aligned <= next_vert_aligned;
			HORIZ_SYNC_OUT <= next_horiz_out;
			VERT_SYNC_OUT <= next_vert_out;
			COMP_BLANK_OUT <= next_blank;
		end
	end

	horiz_plain_a: assert property (@(posedge CLOCK) disable iff (!NRST)
		cfg.hsel == sos_pkg::SOS_H_PLAIN |=> HORIZ_SYNC_OUT == $past(horiz_in))
		else $error("horizontal plain path wrong");

	horiz_flyback_a: assert property (@(posedge CLOCK) disable iff (!NRST)
		cfg.mode == sos_pkg::SOS_MODE_NONE && cfg.hsel == sos_pkg::SOS_H_PLAIN
		|=> HORIZ_SYNC_OUT == $past(src.hfb))
		else $error("flyback not passed");

	horiz_clamp_a: assert property (@(posedge CLOCK) disable iff (!NRST)
		cfg.hsel == sos_pkg::SOS_H_CLAMP |=> HORIZ_SYNC_OUT == $past(src.clamp))
		else $error("clamp not passed");

	horiz_double_a: assert property (@(posedge CLOCK) disable iff (!NRST)
		cfg.hsel == sos_pkg::SOS_H_DBL |=> HORIZ_SYNC_OUT == $past(src.dbl_removed))
		else $error("double removal not passed");

	horiz_comp_a: assert property (@(posedge CLOCK) disable iff (!NRST)
		cfg.mode == sos_pkg::SOS_MODE_COMP && cfg.hsel == sos_pkg::SOS_H_PLAIN
		|=> HORIZ_SYNC_OUT == $past(src.horiz_cs))
		else $error("composite not passed");

	vert_gen_a: assert property (@(posedge CLOCK) disable iff (!NRST)
		cfg.vgen |=> VERT_SYNC_OUT == $past(src.gen_v))
		else $error("generated vertical not passed");

	// separate plain vertical follows pin with two-cycle lag
	vert_sep_a: assert property (@(posedge CLOCK) disable iff (!NRST)
		(cfg.mode == sos_pkg::SOS_MODE_SEP && !cfg.vgen && !cfg.fall_mod && !cfg.h_sync) [*3]
		|-> VERT_SYNC_OUT == $past(src.vpin, 2))
		else $error("vertical pin not passed");

	vert_fall_a: assert property (@(posedge CLOCK) disable iff (!NRST)
		cfg.fall_mod && src.delay_cmp_b && !vert_rise |=> !vert_wave)
		else $error("compare did not end pulse");

	horiz_sog_a: assert property (@(posedge CLOCK) disable iff (!NRST)
		cfg.mode == sos_pkg::SOS_MODE_SOG && cfg.hsel == sos_pkg::SOS_H_PLAIN
		|=> HORIZ_SYNC_OUT == $past(src.green_cs))
		else $error("green sync not passed");

	horiz_sep_a: assert property (@(posedge CLOCK) disable iff (!NRST)
		cfg.mode == sos_pkg::SOS_MODE_SEP && cfg.hsel == sos_pkg::SOS_H_PLAIN
		|=> HORIZ_SYNC_OUT == $past(src.horiz_cs))
		else $error("separate sync not passed");

	horiz_gen_a: assert property (@(posedge CLOCK) disable iff (!NRST)
		cfg.hsel == sos_pkg::SOS_H_GEN |=> HORIZ_SYNC_OUT == $past(src.gen_h))
		else $error("generated horizontal not passed");

	// rise of the chosen input starts the pulse
	vert_rise_a: assert property (@(posedge CLOCK) disable iff (!NRST)
		vert_rise |=> vert_wave)
		else $error("rise did not start pulse");

	vert_plain_fall_a: assert property (@(posedge CLOCK) disable iff (!NRST)
		!cfg.fall_mod && vert_fall && !vert_rise |=> !vert_wave)
		else $error("fall did not end pulse");

	vert_wave_a: assert property (@(posedge CLOCK) disable iff (!NRST)
		!cfg.vgen && !cfg.h_sync |=> VERT_SYNC_OUT == $past(vert_wave))
		else $error("vertical waveform not passed");

	// aligned vertical follows the aligned copy
	vert_align_a: assert property (@(posedge CLOCK) disable iff (!NRST)
		!cfg.vgen && cfg.h_sync |=> VERT_SYNC_OUT == $past(vert_aligned))
		else $error("aligned vertical not passed");

	// held fall waits for the horizontal rise
	vert_hold_a: assert property (@(posedge CLOCK) disable iff (!NRST)
		vert_aligned && !horiz_rise |=> vert_aligned)
		else $error("aligned fall came early");

	hblank_inv_a: assert property (@(posedge CLOCK) disable iff (!NRST)
		cfg.hfb_inv && !src.hfb |=> COMP_BLANK_OUT)
		else $error("horizontal inversion ignored");

	vblank_inv_a: assert property (@(posedge CLOCK) disable iff (!NRST)
		cfg.vfb_inv && !src.vfb |=> COMP_BLANK_OUT)
		else $error("vertical inversion ignored");

	blank_or_a: assert property (@(posedge CLOCK) disable iff (!NRST)
		##1 COMP_BLANK_OUT == ($past(hfb_pos) | $past(vfb_pos) | VERT_SYNC_OUT))
		else $error("blanking wrong");
endmodule : sos_output_select

// [sim/sos_video_sink.sv]
// receiver on the far side of the vertical sync pin
module sos_video_sink (
	input wire logic clk, // system clock
	input wire logic nrst, // reset, low
	input wire logic vsync // vertical sync seen
);
	timeunit 1ns;
	timeprecision 1ps;
	logic v_last;
	int v_rises;
	// counts frame starts; a pure receiver, so it never holds the block up
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			v_last <= 1'b0;
			v_rises <= 0;
		end else begin
			v_last <= vsync;
			v_rises <= v_rises + int'(vsync && !v_last);
		end
	end
endmodule : sos_video_sink

// [sim/tb_sync_output_select.sv]
module tb_sync_output_select;
	timeunit 1ns;
	timeprecision 1ps;
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
$display("mismatch %s exp %h got %h", n, e, g); end end
	logic CLOCK = 1'b0;
	logic NRST = 1'b0;
	logic WR = 1'b0;
	logic RD = 1'b0;
	logic [3:0] ADDR = 4'h0;
	logic [15:0] WDATA = 16'h0000;
	logic [15:0] RDATA;
	logic [15:0] rv;
	logic hs, vs, cb;
	sos_pkg::sos_src_s src = '0;
	int miscompares = 0;
	int num_checks = 0;
	sos_output_select uut (.CLOCK(CLOCK), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
		.RD(RD), .RDATA(RDATA), .HFB_IN(src.hfb), .VFB_IN(src.vfb), .GREEN_CS_IN(src.green_cs),
		.HORIZ_CS_IN(src.horiz_cs), .VPIN_IN(src.vpin), .SEP_VERT(src.sep_vert),
		.DBL_REMOVED(src.dbl_removed), .HORIZ_CLAMP(src.clamp), .GEN_H(src.gen_h),
		.GEN_V(src.gen_v), .DELAY_CMP_B(src.delay_cmp_b), .HORIZ_SYNC_OUT(hs),
		.VERT_SYNC_OUT(vs), .COMP_BLANK_OUT(cb));
	sos_video_sink sink (.clk(CLOCK), .nrst(NRST), .vsync(vs));
	// free-running system clock
	initial begin
		forever #20 CLOCK = ~CLOCK;
	end
	// register port, one-cycle strobes
	task wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge CLOCK);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge CLOCK);
		WR <= 1'b0;
	endtask : wr
	task rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge CLOCK);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge CLOCK);
		RD <= 1'b0;
		#1 d = RDATA;
	endtask : rd
	task cfg(input logic [15:0] sel, input logic [15:0] ctl);
		wr(sos_pkg::SOS_REG_SEL, sel);
		wr(sos_pkg::SOS_REG_CTRL, ctl);
	endtask : cfg
	// pins pass a synchroniser, so allow eight cycles to settle
	task apply(input sos_pkg::sos_src_s v);
		@(posedge CLOCK);
		src <= v;
		repeat (8) @(posedge CLOCK);
		#1;
	endtask : apply
	task pulse_cmp();
		@(posedge CLOCK);
		src.delay_cmp_b <= 1'b1;
		@(posedge CLOCK);
		src.delay_cmp_b <= 1'b0;
	endtask : pulse_cmp
	task t_reset();
		`CHK("hsync", 1'b0, hs)
		`CHK("blank", 1'b0, cb)
		`CHK("vsync", 1'b0, vs)
		rd(sos_pkg::SOS_REG_SEL, rv);
		`CHK("sel", 16'h0000, rv)
		wr(4'hf, 16'hffff);
		rd(4'hf, rv);
		`CHK("unmapped", 16'h0000, rv)
	endtask : t_reset
	// each source alone high, then alone low among all others high
	// double-removed stimulus is a ready-made timer level
	task t_hsel();
		int idx;
		for (int m = 0; m < 4; m++) begin
			for (int h = 0; h < 4; h++) begin
				idx = (h == 0) ? ((m == 0) ? 10 : (m == 1) ? 8 : 7) : 5 - h;
				cfg({11'h000, m[1:0], h[1:0], 1'b0}, 16'h0000);
				apply(11'h001 << idx);
				`CHK("hsync", 1'b1, hs)
				apply(~(11'h001 << idx));
				`CHK("hsync", 1'b0, hs)
			end
		end
	endtask : t_hsel
	task t_vsel();
		int idx;
		for (int m = 0; m < 4; m++) begin
			for (int g = 0; g < 2; g++) begin
				idx = (g == 1) ? 1 : (m == 0) ? 9 : (m == 3) ? 6 : 5;
				cfg({11'h000, m[1:0], 2'b00, g[0]}, 16'h0000);
				apply(11'h001 << idx);
				`CHK("vsync", 1'b1, vs)
				apply(~(11'h001 << idx));
				`CHK("vsync", 1'b0, vs)
			end
		end
	endtask : t_vsel
	// separated pulse held past its fall until the compare match
	task t_fall();
		int n;
		// end any pulse left high before the fall is modified
		apply(11'h000);
		cfg(16'h0008, 16'h0010);
		n = sink.v_rises;
		apply(11'h020);
		apply(11'h000);
		`CHK("vsync", 1'b1, vs)
		pulse_cmp();
		apply(11'h000);
		`CHK("vsync", 1'b0, vs)
		`CHK("vrises", n + 1, sink.v_rises)
	endtask : t_fall
	// fall modified, then held until the horizontal flyback rises
	task t_align();
		cfg(16'h0000, 16'h0018);
		apply(11'h200);
		`CHK("vsync", 1'b1, vs)
		apply(11'h000);
		pulse_cmp();
		apply(11'h000);
		`CHK("vsync", 1'b1, vs)
		apply(11'h400);
		`CHK("vsync", 1'b0, vs)
	endtask : t_align
	task t_blank();
		logic e;
		for (int i = 0; i < 16; i++) begin
			e = (i[1] ^ i[3]) | (i[0] ^ i[2]);
			cfg(16'h0001, {13'h0000, i[3], i[2], 1'b0});
			apply({i[1], i[0], 9'h000});
			`CHK("blank", e, cb)
			rd(sos_pkg::SOS_REG_STAT, rv);
			`CHK("stat", e, rv[0])
		end
		cfg(16'h0001, 16'h0000);
		apply(11'h002);
		`CHK("vsync", 1'b1, vs)
		`CHK("blank", 1'b1, cb)
	endtask : t_blank
	task results();
		if (miscompares == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : results
	// watchdog, about six times the expected run
	initial begin
		#200us;
		miscompares++;
		results();
	end
	initial begin
		repeat (10) @(posedge CLOCK);
		NRST <= 1'b1;
		@(posedge CLOCK);
		#1;
		t_reset();
		t_hsel();
		t_vsel();
		t_fall();
		// flybacks stay aligned: horizontal rises after the held fall
		t_align();
		t_blank();
		results();
	end
endmodule : tb_sync_output_select
